// ==== rtl/hdnu_consts.vh ====
// Constants for the half-duplex nine-bit serial port
`ifndef HDNU_CONSTS_VH
`define HDNU_CONSTS_VH
`define HDNU_ADDR_DATA 8'hD6
`define HDNU_ADDR_CTRL 8'hD7
`define HDNU_CTRL_RESET 8'h00
`define HDNU_BIT_RX_READY_FLAG 7
`define HDNU_BIT_TX_EMPTY_FLAG 6
`define HDNU_BIT_RX_IRQ_ENABLE 5
`define HDNU_BIT_TX_IRQ_ENABLE 4
`define HDNU_BIT_BAUD_HI 3
`define HDNU_BIT_BAUD_LO 1
`define HDNU_BIT_NINTH 0
`define HDNU_DIV_0 13'd6656
`define HDNU_DIV_1 13'd3328
`define HDNU_DIV_2 13'd1664
`define HDNU_DIV_3 13'd832
`define HDNU_DIV_4 13'd416
`define HDNU_DIV_5 13'd256
`define HDNU_DIV_6 13'd208
`define HDNU_OVERSAMPLE 8
`define HDNU_DATA_BITS 9
`define HDNU_SAMPLE_A 3'd2
`define HDNU_SAMPLE_B 3'd3
`define HDNU_SAMPLE_C 3'd4
`endif

// ==== rtl/hdnu_baud_gen.v ====
// Baud tick generator at eight times the bit rate
`timescale 1ns/1ps
`include "hdnu_consts.vh"
module hdnu_baud_gen (
    input wire clk,
    input wire rstn,
    input wire [2:0] baud_select,
    input wire restart,
    output reg tick
);
    reg [12:0] divisor;
    reg [12:0] count;
    // Table of internal-clock divisors per baud code
    always @* begin
        case (baud_select)
            3'd0: divisor = `HDNU_DIV_0;
            3'd1: divisor = `HDNU_DIV_1;
            3'd2: divisor = `HDNU_DIV_2;
            3'd3: divisor = `HDNU_DIV_3;
            3'd4: divisor = `HDNU_DIV_4;
            3'd5: divisor = `HDNU_DIV_5;
            3'd6: divisor = `HDNU_DIV_6;
            default: divisor = `HDNU_DIV_6;
        endcase
    end
    // Tick every divisor/8 clocks
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= 13'h0000;
            tick <= 1'b0;
        end else if (restart) begin
            count <= 13'h0000;
            tick <= 1'b0;
        end else if (count >= (divisor >> 3) - 13'h0001) begin
            count <= 13'h0000;
            tick <= 1'b1;
        end else begin
            count <= count + 13'h0001;
            tick <= 1'b0;
        end
    end
endmodule // hdnu_baud_gen

// ==== rtl/hdnu_vote.v ====
// Two-of-three majority vote over timed samples
`timescale 1ns/1ps
`include "hdnu_consts.vh"
module hdnu_vote (
    input wire clk,
    input wire rstn,
    input wire tick,
    input wire [2:0] phase,
    input wire rx_in,
    output wire bit_value
);
    reg [2:0] samples;
    integer i;
    // Capture three samples inside the eight states of a bit
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            samples <= 3'h7;
        end else if (tick) begin
            for (i = 0; i < 3; i = i + 1) begin
                if (phase == `HDNU_SAMPLE_A + i[2:0]) begin
                    samples[i] <= rx_in;
                end
            end
        end
    end
    assign bit_value = (samples[0] & samples[1]) | (samples[1] & samples[2]) | (samples[0] & samples[2]);
endmodule // hdnu_vote

// ==== rtl/hdnu_uart.v ====
// Half-duplex nine-bit serial port with AHB-Lite register slave
`timescale 1ns/1ps
`include "hdnu_consts.vh"
module hdnu_uart (
    input wire clk,
    input wire rstn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire receive_line,
    input wire port_output_value,
    output wire transmit_line,
    output wire tx_output_select,
    output wire tx_irq,
    output wire rx_irq
);
    localparam ST_IDLE = 2'd0;
    localparam ST_TX = 2'd1;
    localparam ST_RX = 2'd2;

    reg [1:0] state;
    reg rx_ready_flag;
    reg tx_empty_flag;
    reg rx_irq_enable;
    reg tx_irq_enable;
    reg [2:0] baud_select;
    reg ninth_bit_value;
    reg [7:0] rx_buffer;
    reg [8:0] shift;
    reg [3:0] bit_index;
    reg [2:0] phase;
    reg tx_level;
    reg rx_prev;
    reg wr_pending;
    reg [7:0] wr_addr;
    reg [7:0] rd_addr;
    reg rd_pending;
    wire tick;
    wire voted;
    wire data_write;
    wire ctrl_write;
    wire addr_phase;
    wire falling;
    wire tx_done;
    wire rx_done;
    wire [7:0] ctrl_value;

    // AHB-Lite address phase, zero wait states
    assign addr_phase = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign data_write = wr_pending && (wr_addr == `HDNU_ADDR_DATA);
    assign ctrl_write = wr_pending && (wr_addr == `HDNU_ADDR_CTRL);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pending <= 1'b0;
            rd_pending <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
        end else begin
            // Register index is the word address: byte address is four times the index
            wr_pending <= addr_phase && hwrite && (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
            rd_pending <= addr_phase && !hwrite;
            wr_addr <= haddr[9:2];
            rd_addr <= haddr[9:2];
        end
    end

    // Control register image
    assign ctrl_value = {rx_ready_flag, tx_empty_flag, rx_irq_enable, tx_irq_enable, baud_select,
        ninth_bit_value};

    // Read data launched from flip-flops; unmapped reads below 0x400 give zero, reads above keep the old hrdata
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite && haddr[31:10] == 22'h000000) begin
            if (haddr[9:2] == `HDNU_ADDR_DATA) begin
                hrdata <= {24'h000000, rx_buffer};
            end else if (haddr[9:2] == `HDNU_ADDR_CTRL) begin
                hrdata <= {24'h000000, ctrl_value};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    hdnu_baud_gen u_baud (
        .clk(clk),
        .rstn(rstn),
        .baud_select(baud_select),
        .restart(data_write || ((state == ST_IDLE) && falling)),
        .tick(tick)
    );

    hdnu_vote u_vote (
        .clk(clk),
        .rstn(rstn),
        .tick(tick),
        .phase(phase),
        .rx_in(receive_line),
        .bit_value(voted)
    );

    // Edge watch only while idle, neither transmitting nor receiving
    assign falling = rx_prev && !receive_line && (state == ST_IDLE);
    assign tx_done = (state == ST_TX) && tick && (phase == 3'd7) && (bit_index == 4'd10);
    assign rx_done = (state == ST_RX) && tick && (phase == 3'd7) && (bit_index == 4'd10);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= receive_line;
        end
    end

    // Shared shift engine; bit_index 0 start, 1..9 data, 10 stop
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            shift <= 9'h000;
            bit_index <= 4'h0;
            phase <= 3'h0;
            tx_level <= 1'b1;
            rx_buffer <= 8'h00;
        end else if (data_write) begin
            // Transmission pre-empts reception
            state <= ST_TX;
            shift <= {ninth_bit_value, hwdata[7:0]};
            bit_index <= 4'h0;
            phase <= 3'h0;
            tx_level <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    tx_level <= 1'b1;
                    if (falling) begin
                        state <= ST_RX;
                        bit_index <= 4'h0;
                        phase <= 3'h0;
                    end
                end
                ST_TX: begin
                    if (tick) begin
                        phase <= phase + 3'h1;
                        if (phase == 3'd7) begin
                            bit_index <= bit_index + 4'h1;
                            if (bit_index == 4'd10) begin
                                state <= ST_IDLE;
                                tx_level <= 1'b1;
                            end else if (bit_index == 4'd9) begin
                                tx_level <= 1'b1;
                            end else begin
                                tx_level <= shift[0];
                                shift <= {1'b0, shift[8:1]};
                            end
                        end
                    end
                end
                ST_RX: begin
                    if (tick) begin
                        phase <= phase + 3'h1;
                        if (phase == 3'd7) begin
                            bit_index <= bit_index + 4'h1;
                            if (bit_index >= 4'd1 && bit_index <= 4'd9) begin
                                shift <= {voted, shift[8:1]};
                            end
                            if (bit_index == 4'd10) begin
                                rx_buffer <= shift[7:0];
                                state <= ST_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Control register and flags; hardware set wins over software clear
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_ready_flag <= 1'b0;
            tx_empty_flag <= 1'b0;
            rx_irq_enable <= 1'b0;
            tx_irq_enable <= 1'b0;
            baud_select <= 3'h0;
            ninth_bit_value <= 1'b0;
        end else begin
            if (ctrl_write) begin
                rx_irq_enable <= hwdata[`HDNU_BIT_RX_IRQ_ENABLE];
                tx_irq_enable <= hwdata[`HDNU_BIT_TX_IRQ_ENABLE];
                baud_select <= hwdata[`HDNU_BIT_BAUD_HI:`HDNU_BIT_BAUD_LO];
                ninth_bit_value <= hwdata[`HDNU_BIT_NINTH];
                rx_ready_flag <= hwdata[`HDNU_BIT_RX_READY_FLAG];
                tx_empty_flag <= hwdata[`HDNU_BIT_TX_EMPTY_FLAG];
            end
            if (data_write) begin
                tx_empty_flag <= 1'b0;
            end
            if (tx_done) begin
                tx_empty_flag <= 1'b1;
            end
            if (rx_done) begin
                rx_ready_flag <= 1'b1;
                ninth_bit_value <= shift[8];
            end
        end
    end

    // Outputs: inverted data, port value when not transmitting
    assign tx_output_select = (state == ST_TX);
    assign transmit_line = tx_output_select ? ~tx_level : port_output_value;
    assign tx_irq = tx_empty_flag && tx_irq_enable;
    assign rx_irq = rx_ready_flag && rx_irq_enable;
endmodule // hdnu_uart

// ==== verification/hdnu_uart_props.sv ====
// Checker for the half-duplex nine-bit serial port
`timescale 1ns/1ps
`include "hdnu_consts.vh"
module hdnu_uart_props (
    input wire clk,
    input wire rstn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire port_output_value,
    input wire transmit_line,
    input wire tx_output_select,
    input wire tx_irq,
    input wire rx_irq
);
    logic dw_pend, cw_pend, en_tx, en_rx;
    logic [19:0] hi_cnt;
    wire take = hsel & hready & htrans[1] & hwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Data phase tracking and enable shadow
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dw_pend <= 1'b0;
            cw_pend <= 1'b0;
            en_tx <= 1'b0;
            en_rx <= 1'b0;
            hi_cnt <= 20'h0;
        end else begin
            dw_pend <= take & (haddr == {22'h0, `HDNU_ADDR_DATA, 2'b00});
            cw_pend <= take & (haddr == {22'h0, `HDNU_ADDR_CTRL, 2'b00});
            if (cw_pend) en_tx <= hwdata[`HDNU_BIT_TX_IRQ_ENABLE];
            if (cw_pend) en_rx <= hwdata[`HDNU_BIT_RX_IRQ_ENABLE];
            hi_cnt <= tx_output_select ? hi_cnt + 20'h1 : 20'h0;
        end
    end
    pin_follow_a: assert property (!tx_output_select |-> transmit_line == port_output_value)
        else $error("pin not following port value");
    start_high_a: assert property ($rose(tx_output_select) |-> transmit_line)
        else $error("start bit not inverted");
    stop_low_a: assert property ($fell(tx_output_select) |-> !$past(transmit_line))
        else $error("stop bit not inverted");
    write_starts_a: assert property (dw_pend |=> tx_output_select)
        else $error("data write did not start frame");
    start_cause_a: assert property ($rose(tx_output_select) |-> $past(dw_pend))
        else $error("frame without data write");
    frame_len_a: assert property ($fell(tx_output_select) |-> hi_cnt >= 2287 && hi_cnt <= 73217)
        else $error("frame length out of range");
    tx_done_irq_a: assert property ($fell(tx_output_select) && en_tx |-> ##[0:2] tx_irq)
        else $error("no transmit interrupt");
    tx_gate_a: assert property (!en_tx |-> !tx_irq)
        else $error("transmit interrupt not gated");
    rx_gate_a: assert property (!en_rx |-> !rx_irq)
        else $error("receive interrupt not gated");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bad bus response");
    cover property ($rose(tx_output_select));
    cover property ($rose(rx_irq));
    cover property ($rose(tx_irq));
endmodule // hdnu_uart_props
bind hdnu_uart hdnu_uart_props chk (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .port_output_value, .transmit_line, .tx_output_select, .tx_irq, .rx_irq);

// ==== verification/hdnu_remote.sv ====
// Remote serial station model
`timescale 1ns/1ps
module hdnu_remote (
    input wire clk,
    input wire transmit_line,
    input wire tx_output_select,
    output logic receive_line
);
    int bit_clks = 208;
    logic [8:0] got;
    logic frame_ok;
    initial receive_line = 1'b1;
    // Low start, nine data LSB first, high stop; n_bits cuts it short
    task automatic send(input logic [8:0] w, input int n_bits);
        logic [10:0] f;
        f = {1'b1, w, 1'b0};
        for (int i = 0; i < n_bits; i++) begin
            receive_line <= f[i];
            repeat (bit_clks) @(posedge clk);
        end
        receive_line <= 1'b1;
    endtask
    // Undo pin inversion at mid-bit of eleven bits
    always @(posedge tx_output_select) begin : mon
        logic [10:0] s;
        repeat (bit_clks / 2) @(negedge clk);
        for (int i = 0; i < 11; i++) begin
            s[i] = ~transmit_line;
            if (i < 10) repeat (bit_clks) @(negedge clk);
        end
        got = s[9:1];
        frame_ok = !s[0] && s[10];
    end
endmodule // hdnu_remote

// ==== verification/tb_top.sv ====
// Self-checking bench for the nine-bit serial port
`timescale 1ns/1ps
`include "hdnu_consts.vh"
module tb_top;
    logic clk, rstn, hwrite, port_output_value, hreadyout, hresp, transmit_line, tx_output_select;
    logic tx_irq, rx_irq, receive_line;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int failures = 0, samples_checked = 0, len;
    logic [7:0] b;
    logic [8:0] w;
    logic [2:0] code;
    hdnu_uart uut (.clk(clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .receive_line(receive_line), .port_output_value(port_output_value),
        .transmit_line(transmit_line), .tx_output_select(tx_output_select), .tx_irq(tx_irq), .rx_irq(rx_irq));
    hdnu_remote remote (.clk(clk), .transmit_line(transmit_line), .tx_output_select(tx_output_select),
        .receive_line(receive_line));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic int div_of(input logic [2:0] c);
        int t[8] = '{6656, 3328, 1664, 832, 416, 256, 208, 208};
        return t[c];
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(negedge clk);
    endtask
    task automatic wait_tx();
        len = 0;
        while (tx_output_select !== 1'b1) @(negedge clk);
        while (tx_output_select === 1'b1) begin
            @(negedge clk);
            len++;
        end
    endtask
    task automatic end_sim();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #500000;
        failures++;
        end_sim();
    end
    initial begin
        rstn = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        port_output_value = 1'b1;
        void'($urandom(32'hc24970ae));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        bus(0, `HDNU_ADDR_CTRL, 8'h00);
        check(rd[15:0], 16'h0);
        bus(0, 8'h40, 8'h00);
        check(rd[15:0], 16'h0);
        for (int k = 0; k < 3; k++) begin
            code = 3'd6 - k[2:0];
            {w, b} = $urandom;
            remote.bit_clks = div_of(code);
            bus(1, `HDNU_ADDR_CTRL, {4'h1, code, w[0]});
            bus(1, `HDNU_ADDR_DATA, b);
            wait_tx();
            check(16'(len > 11 * div_of(code) - 2 && len < 11 * div_of(code) + 2), 16'h1);
            check({6'h0, remote.frame_ok, remote.got}, {7'h1, w[0], b});
            bus(0, `HDNU_ADDR_CTRL, 8'h00);
            check(rd[15:0], {8'h0, 4'h5, code, w[0]});
            check(16'(tx_irq), 16'h1);
        end
        for (int v = 0; v < 2; v++) begin
            bus(1, `HDNU_ADDR_CTRL, {1'b0, v[0], 6'h1C});
            check(16'(tx_irq), 16'(v));
        end
        bus(1, `HDNU_ADDR_DATA, 8'h5A);
        bus(0, `HDNU_ADDR_CTRL, 8'h00);
        check(16'(rd[6]), 16'h0);
        wait_tx();
        remote.bit_clks = 208;
        w = $urandom;
        bus(1, `HDNU_ADDR_CTRL, 8'h2C);
        remote.send(w, 11);
        for (int i = 0; i < 600 && rx_irq !== 1'b1; i++) @(negedge clk);
        check(16'(rx_irq), 16'h1);
        bus(0, `HDNU_ADDR_DATA, 8'h00);
        check(rd[15:0], {8'h0, w[7:0]});
        bus(0, `HDNU_ADDR_CTRL, 8'h00);
        check(rd[15:0], {8'h0, 7'h56, w[8]});
        for (int v = 1; v >= 0; v--) begin
            bus(1, `HDNU_ADDR_CTRL, {v[0], 7'h2C});
            check(16'(rx_irq), 16'(v));
        end
        fork
            remote.send(9'h1F0, 4);
        join_none
        repeat (400) @(posedge clk);
        bus(1, `HDNU_ADDR_DATA, 8'hC3);
        wait_tx();
        check(16'(len > 11 * 208 - 2 && len < 11 * 208 + 2), 16'h1);
        repeat (700) @(posedge clk);
        bus(0, `HDNU_ADDR_CTRL, 8'h00);
        check(16'(rd[7]), 16'h0);
        end_sim();
    end
endmodule // tb_top
